// ==== shared/cstore_pkg.sv ====
// shared constants and types for the conditional store and prefix block
package cstore_pkg;
  // instruction word fields
  localparam int OP_LO    = 30;
  localparam int OP3_LO   = 19;
  localparam int IMM_BIT  = 13;
  localparam int SIMM_LO  = 5;
  localparam int OP2_LO   = 22;
  localparam int CMB_BIT  = 29;
  localparam int F_PAIR   = 28;
  localparam int F_DST_LO = 25;
  localparam int F_S1_LO  = 19;
  localparam int F_S2_LO  = 16;
  localparam int F_S3_LO  = 13;
  localparam int S_PAIR   = 12;
  localparam int S_DST_LO = 9;
  localparam int S_S1_LO  = 6;
  localparam int S_S2_LO  = 3;
  localparam int S_S3_LO  = 0;
  localparam logic [1:0] OP_FMT2    = 2'h0;
  localparam logic [1:0] OP_FMT3    = 2'h3;
  localparam logic [5:0] OP3_SGL    = 6'h2C;
  localparam logic [5:0] OP3_DBL    = 6'h2F;
  localparam logic [2:0] OP2_PREFIX = 3'h7;
  localparam logic [2:0] URS1_MAX   = 3'h1;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ATTR   = 8'h08;
  localparam logic [7:0] REG_STORES = 8'h0C;
  localparam logic [7:0] REG_EXCS   = 8'h10;
  localparam logic [1:0] CTRL_RST   = 2'h2;
  localparam int CTRL_DBL_SET = 0;
  localparam int CTRL_MMU     = 1;
  // byte masks and half steps
  localparam logic [7:0]  MASK_LO   = 8'h0F;
  localparam logic [7:0]  MASK_HI   = 8'hF0;
  localparam logic [7:0]  MASK_ALL  = 8'hFF;
  localparam logic [63:0] STEP_SGL  = 64'h4;
  localparam logic [63:0] STEP_DBL  = 64'h8;

  typedef enum logic [3:0] {
    EXC_NONE      = 4'h0,
    EXC_ILL_INSTR = 4'h1,
    EXC_FP_DIS    = 4'h2,
    EXC_ILL_ACT   = 4'h3,
    EXC_MISALIGN  = 4'h4,
    EXC_DBL_MIS   = 4'h5,
    EXC_WATCH     = 4'h6,
    EXC_TLB_MISS  = 4'h7,
    EXC_DACC      = 4'h8,
    EXC_DERR      = 4'h9,
    EXC_PROT      = 4'hA
  } exc_e;

  typedef enum logic [1:0] {
    PERM_OK   = 2'h0,
    PERM_EXC  = 2'h1,
    PERM_ERR  = 2'h2,
    PERM_PROT = 2'h3
  } perm_e;

  typedef struct packed {
    logic       paired;
    logic [2:0] dest;
    logic [2:0] src1;
    logic [2:0] src2;
    logic [2:0] src3;
  } ext_attr_s;

  typedef struct packed {
    logic [63:0] addr;
    logic [63:0] data;
    logic [7:0]  mask;
  } store_req_s;

  typedef struct packed {
    logic valid;
    exc_e code;
  } exc_s;
endpackage : cstore_pkg

// ==== core/align_check.sv ====
// alignment checks for single, double and paired conditional stores
`timescale 1ns/100ps
module align_check (
  input  wire logic [3:0] addr_lo,
  input  wire logic       dbl,
  input  wire logic       paired,
  output logic            gen_mis,
  output logic            dbl_mis
);
  wire any4  = addr_lo[1:0] != 2'h0;
  wire any8  = addr_lo[2:0] != 3'h0;
  wire any16 = addr_lo[3:0] != 4'h0;
  // paired double never takes the double-specific fault
  assign gen_mis = paired ? (dbl ? any16 : any8) : (dbl ? any4 : any4);
  assign dbl_mis = dbl & ~paired & ~any4 & any8;
endmodule : align_check

// ==== core/cond_fp_store_prefix.sv ====
// conditional floating-point store and instruction prefix execution unit
`timescale 1ns/100ps
module cond_fp_store_prefix (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  input  wire logic                    ins_valid,
  output logic                         ins_ready,
  input  wire logic [31:0]             ins_word,
  input  wire logic                    ins_delay_slot,
  input  wire logic [63:0]             src1_val,
  input  wire logic                    cond_sign,
  input  wire logic [63:0]             st_data_basic,
  input  wire logic [63:0]             st_data_ext,
  input  wire logic                    proc_state_fp_enable,
  input  wire logic                    fp_status_enable,
  output logic                         lookup_req,
  output logic [63:0]                  lookup_addr,
  output logic [63:0]                  lookup_addr_ext,
  input  wire logic                    tlb_miss,
  input  wire cstore_pkg::perm_e       perm_fault,
  input  wire logic                    noncacheable,
  input  wire logic                    phys_ext_cache_space,
  input  wire logic                    wp_hit_basic,
  input  wire logic                    wp_hit_ext,
  output logic                         st_valid,
  input  wire logic                    st_ready,
  output cstore_pkg::store_req_s       st_req,
  output cstore_pkg::exc_s             exc,
  output logic                         insert_toc
);
  import cstore_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BASIC = 2'b01,
    ST_EXT   = 2'b10
  } st_state_e;

  st_state_e   state_ff;
  st_state_e   nxt_state;
  store_req_s  st_ff;
  store_req_s  nxt_st;
  store_req_s  ext_ff;
  logic        paired_ff;
  logic        st_zero_ff;
  logic        ext_valid_ff;
  logic [1:0]  remain_ff;
  ext_attr_s   cur_ff;
  ext_attr_s   next_ff;
  exc_s        exc_ff;
  logic        toc_ff;
  logic [1:0]  ctrl_ff;
  logic [31:0] stores_ff;
  logic [31:0] excs_ff;
  logic [31:0] rdata_ff;
  logic        wr_ff;
  logic [7:0]  waddr_ff;
  exc_e        cs_code;
  exc_e        perm_code;

  // instruction decode
  wire [1:0] op       = ins_word[OP_LO+:2];
  wire [5:0] op3      = ins_word[OP3_LO+:6];
  wire       is_dbl   = op3 == OP3_DBL;
  wire       is_cst   = (op == OP_FMT3) & (op3 == OP3_SGL | is_dbl);
  wire       is_pfx   = (op == OP_FMT2) &
                        (ins_word[OP2_LO+:3] == OP2_PREFIX);
  wire       imm_sel  = ins_word[IMM_BIT];
  wire [7:0] simm     = ins_word[SIMM_LO+:8];
  wire       accept   = ins_valid & ins_ready;
  wire       mmu_en   = ctrl_ff[CTRL_MMU];
  wire       paired   = ext_valid_ff & cur_ff.paired;
  wire       fp_ok    = proc_state_fp_enable & fp_status_enable;

  wire [63:0] ea     = src1_val + {{54{simm[7]}}, simm, 2'b00};
  wire [63:0] ea_ext = ea + (is_dbl ? STEP_DBL : STEP_SGL);

  wire cond = is_dbl ? (cond_sign == ctrl_ff[CTRL_DBL_SET]) : cond_sign;

  wire act_bad = ext_valid_ff &
                 ((cur_ff.src1 > URS1_MAX) | cur_ff.src3[2] |
                  (cur_ff.paired & (cur_ff.src2[2] | cur_ff.dest[2])));

  logic gen_mis;
  logic dbl_mis;

  align_check u_align (
    .addr_lo (ea[3:0]),
    .dbl     (is_dbl),
    .paired  (paired),
    .gen_mis (gen_mis),
    .dbl_mis (dbl_mis)
  );

  wire wp_hit = wp_hit_basic | (paired & wp_hit_ext);
  wire pair_nc = paired & noncacheable & ~phys_ext_cache_space;

  assign perm_code = (perm_fault == PERM_EXC) ? EXC_DACC :
                     (perm_fault == PERM_ERR) ? EXC_DERR :
                     (perm_fault == PERM_PROT) ? EXC_PROT : EXC_NONE;

  // fault priority: i-bit, enable, fields, alignment
  // memory checks; none of them look at the store condition
  assign cs_code = !imm_sel           ? EXC_ILL_INSTR :
                   !fp_ok             ? EXC_FP_DIS :
                   act_bad            ? EXC_ILL_ACT :
                   gen_mis            ? EXC_MISALIGN :
                   dbl_mis            ? EXC_DBL_MIS :
                   wp_hit             ? EXC_WATCH :
                   (mmu_en & tlb_miss) ? EXC_TLB_MISS :
                   pair_nc            ? EXC_DACC :
                   mmu_en             ? perm_code : EXC_NONE;

  wire pfx_bad  = accept & is_pfx & ext_valid_ff;
  wire pfx_load = accept & is_pfx & ~ext_valid_ff;
  wire cs_take  = accept & is_cst;
  wire cs_fault = cs_take & (cs_code != EXC_NONE);
  // suppressed store still writes when noncacheable
  wire need_wr  = cond | noncacheable;
  wire cs_go    = cs_take & ~cs_fault & need_wr;
  wire consume  = accept & ~is_pfx & ext_valid_ff;

  // lookup issued whether or not the store happens
  assign lookup_req      = cs_take & imm_sel & mmu_en;
  assign lookup_addr     = ea;
  assign lookup_addr_ext = ea_ext;

  // byte lanes for a half; all zero when the store is suppressed
  function automatic logic [7:0] lane_mask(input logic [63:0] a,
                                           input logic d,
                                           input logic c);
    logic [7:0] m;
    m = d ? MASK_ALL : (a[2] ? MASK_HI : MASK_LO);
    return c ? m : 8'h00;
  endfunction : lane_mask

  // store sequencer; the extended half waits behind the basic one,
  // trading a cycle for plain store ordering
  always_comb begin
    nxt_state = state_ff;
    nxt_st    = st_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (cs_go) begin
          nxt_state = ST_BASIC;
          nxt_st    = '{ea, st_data_basic, lane_mask(ea, is_dbl, cond)};
        end
      end
      ST_BASIC: begin
        if (st_ready && paired_ff) begin
          nxt_state = ST_EXT;
          nxt_st    = ext_ff;
        end else if (st_ready) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_EXT: begin
        if (st_ready) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  assign ins_ready = state_ff == ST_IDLE;
  assign st_valid  = state_ff != ST_IDLE;
  assign st_req    = st_ff;
  assign exc       = exc_ff;
  assign insert_toc = toc_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_IDLE;
      st_ff    <= '0;
    end else begin
      state_ff <= nxt_state;
      st_ff    <= nxt_st;
    end
  end

  // extended half captured with the basic one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_ff     <= '0;
      paired_ff  <= 1'b0;
      st_zero_ff <= 1'b0;
    end else if (cs_go) begin
      ext_ff     <= '{ea_ext, st_data_ext, lane_mask(ea_ext, is_dbl, cond)};
      paired_ff  <= paired;
      st_zero_ff <= ~cond;
    end
  end

  // fault report, one cycle after the instruction is taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exc_ff <= '{1'b0, EXC_NONE};
    end else if (pfx_bad) begin
      exc_ff <= '{1'b1, EXC_ILL_ACT};
    end else if (cs_fault) begin
      exc_ff <= '{1'b1, cs_code};
    end else begin
      exc_ff <= '{1'b0, EXC_NONE};
    end
  end

  // trap instruction when prefix is not followed in line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      toc_ff <= 1'b0;
    end else begin
      toc_ff <= pfx_load & ins_delay_slot;
    end
  end

  // prefix fields, second set dropped for one-only
  wire       cmb  = ins_word[CMB_BIT];
  wire ext_attr_s first_f = '{ins_word[F_PAIR], ins_word[F_DST_LO+:3],
                              ins_word[F_S1_LO+:3], ins_word[F_S2_LO+:3],
                              ins_word[F_S3_LO+:3]};
  wire ext_attr_s second_f = '{ins_word[S_PAIR], ins_word[S_DST_LO+:3],
                               ins_word[S_S1_LO+:3], ins_word[S_S2_LO+:3],
                               ins_word[S_S3_LO+:3]};

  // attribute consumed by each covered instruction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_valid_ff <= 1'b0;
      remain_ff    <= 2'h0;
      cur_ff       <= '0;
      next_ff      <= '0;
    end else if (pfx_load) begin
      ext_valid_ff <= 1'b1;
      remain_ff    <= cmb ? 2'h2 : 2'h1;
      cur_ff       <= first_f;
      next_ff      <= cmb ? second_f : '0;
    end else if (consume && remain_ff == 2'h2) begin
      remain_ff    <= 2'h1;
      cur_ff       <= next_ff;
    end else if (consume) begin
      ext_valid_ff <= 1'b0;
      remain_ff    <= 2'h0;
      cur_ff       <= '0;
    end
  end

  // software-visible counters, wrap silently
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stores_ff <= 32'h0;
      excs_ff   <= 32'h0;
    end else begin
      stores_ff <= stores_ff + {31'h0, st_valid & st_ready};
      excs_ff   <= excs_ff + {31'h0, exc_ff.valid};
    end
  end

  // bus slave: zero wait states, read data fetched in address phase
  wire       ahb_go = hsel & htrans[1] & hready;
  wire [7:0] aoff   = haddr[7:0];
  wire [31:0] rsel  =
    (aoff == REG_CTRL)   ? {30'h0, ctrl_ff} :
    (aoff == REG_STATUS) ? {22'h0, exc_ff.code, st_valid,
                            remain_ff, toc_ff, ext_valid_ff, 1'b0} :
    (aoff == REG_ATTR)   ? {18'h0, ext_valid_ff, cur_ff} :
    (aoff == REG_STORES) ? stores_ff :
    (aoff == REG_EXCS)   ? excs_ff : 32'h0;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 32'h0;
      wr_ff    <= 1'b0;
      waddr_ff <= 8'h0;
    end else begin
      rdata_ff <= (ahb_go & ~hwrite) ? rsel : rdata_ff;
      wr_ff    <= ahb_go & hwrite;
      waddr_ff <= aoff;
    end
  end

  // only the control word is writable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_ff && waddr_ff == REG_CTRL) begin
      ctrl_ff <= hwdata[1:0];
    end
  end

  sequence s_basic_done;
    state_ff == ST_BASIC && st_ready && paired_ff;
  endsequence

  sequence s_ext_up;
    state_ff == ST_EXT && st_valid;
  endsequence

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_imm_select: assert property (
    cs_take && !imm_sel |=> exc.valid && exc.code == EXC_ILL_INSTR)
    else $error("immediate-select zero not refused");

  a_fp_disable: assert property (
    cs_take && imm_sel && !fp_ok |=> exc.code == EXC_FP_DIS)
    else $error("fp disabled fault missing");

  a_prefix_twice: assert property (
    pfx_bad |=> exc.valid && exc.code == EXC_ILL_ACT && ext_valid_ff)
    else $error("prefix over valid attribute not refused");

  a_prefix_count: assert property (
    pfx_load |=> ext_valid_ff && remain_ff == ($past(cmb) ? 2'h2 : 2'h1))
    else $error("prefix coverage count wrong");

  a_attr_clear: assert property (
    consume && remain_ff == 2'h1 |=> !ext_valid_ff && !exc.valid
      || !ext_valid_ff)
    else $error("attribute not cleared after last use");

  a_zero_mask: assert property (
    st_valid && st_zero_ff |-> st_req.mask == 8'h00)
    else $error("suppressed store carries lanes");

  a_pair_order: assert property (
    s_basic_done |=> s_ext_up ##0 st_req.addr == $past(ext_ff.addr))
    else $error("extended half not issued after basic");

  a_fault_nostore: assert property (
    cs_fault |=> state_ff == ST_IDLE && exc.valid)
    else $error("faulting store reached memory");

  a_tlb_miss: assert property (
    cs_take && imm_sel && fp_ok && !act_bad && !gen_mis && !dbl_mis
      && !wp_hit && mmu_en && tlb_miss |=> exc.code == EXC_TLB_MISS)
    else $error("translation miss not reported");

  a_watch_supp: assert property (
    cs_take && imm_sel && fp_ok && !act_bad && !gen_mis && !dbl_mis
      && wp_hit |=> exc.code == EXC_WATCH)
    else $error("watchpoint lost on conditional store");

  a_toc_insert: assert property (
    pfx_load && ins_delay_slot |=> insert_toc ##1 !insert_toc)
    else $error("trap instruction not inserted");
endmodule : cond_fp_store_prefix

// ==== tb/mem_side_model.sv ====
// far side model: translation answers and store acceptance with stalls
`timescale 1ns/100ps
module mem_side_model (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          lookup_req,
  input  wire logic          st_valid,
  input  wire logic [4:0]    cfg,
  input  wire logic [1:0]    perm_cfg,
  input  wire logic [1:0]    stall,
  output logic               tlb_miss,
  output cstore_pkg::perm_e  perm_fault,
  output logic               noncacheable,
  output logic               phys_ext_cache_space,
  output logic               wp_hit_basic,
  output logic               wp_hit_ext,
  output logic               st_ready
);
  import cstore_pkg::*;
  logic [1:0] wait_ff;
  logic [1:0] nxt_wait;
  // translation answers mean nothing without a lookup, so show the inverse
  assign tlb_miss = lookup_req ? cfg[0] : ~cfg[0];
  assign perm_fault = perm_e'(lookup_req ? perm_cfg : ~perm_cfg);
  assign noncacheable = cfg[1];
  assign phys_ext_cache_space = cfg[2];
  assign wp_hit_basic = cfg[3];
  assign wp_hit_ext = cfg[4];
  // one half accepted at a time after the chosen stall
  assign st_ready = st_valid && (wait_ff == stall);
  assign nxt_wait = (!st_valid || st_ready) ? 2'h0 : wait_ff + 2'h1;
  // stall counter restarts after every accepted half
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_ff <= 2'h0;
    end else begin
      wait_ff <= nxt_wait;
    end
  end
endmodule : mem_side_model

// ==== tb/cond_fp_store_prefix_tb.sv ====
// self-checking bench for the conditional store and prefix unit
`timescale 1ns/100ps
module cond_fp_store_prefix_tb;
  import cstore_pkg::*;
  typedef struct {
    logic [1:0]  kind;
    exc_e        code;
    logic [63:0] addr;
    logic [63:0] data;
    logic [7:0]  mask;
  } note_s;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, ins_word, rd, lfsr_ff;
  logic [1:0]  htrans, perm_cfg, stall;
  logic [2:0]  hsize;
  logic        ins_valid, ins_ready, ins_delay_slot, cond_sign, lookup_req;
  logic        proc_state_fp_enable, fp_status_enable, insert_toc;
  logic [63:0] src1_val, st_data_basic, st_data_ext, b;
  logic [63:0] lookup_addr, lookup_addr_ext;
  logic        tlb_miss, noncacheable, phys_ext_cache_space;
  logic        wp_hit_basic, wp_hit_ext, st_valid, st_ready;
  logic [4:0]  cfg;
  perm_e       perm_fault;
  store_req_s  st_req;
  exc_s        exc;
  note_s       exp_q[$];
  note_s       cur;
  int          errors, samples_checked, n_exc, n_st;
  logic        mmu;
  assign hready = hreadyout;

  cond_fp_store_prefix i_cond_fp_store_prefix (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .ins_valid, .ins_ready, .ins_word,
    .ins_delay_slot, .src1_val, .cond_sign, .st_data_basic, .st_data_ext,
    .proc_state_fp_enable, .fp_status_enable, .lookup_req, .lookup_addr,
    .lookup_addr_ext, .tlb_miss, .perm_fault, .noncacheable,
    .phys_ext_cache_space, .wp_hit_basic, .wp_hit_ext, .st_valid, .st_ready,
    .st_req, .exc, .insert_toc
  );
  mem_side_model i_mem_side_model (
    .hclk, .hresetn, .lookup_req, .st_valid, .cfg, .perm_cfg, .stall,
    .tlb_miss, .perm_fault, .noncacheable, .phys_ext_cache_space,
    .wp_hit_basic, .wp_hit_ext, .st_ready
  );

  function automatic logic [63:0] rnd();
    lfsr_ff = {lfsr_ff[30:0],
               lfsr_ff[31] ^ lfsr_ff[21] ^ lfsr_ff[1] ^ lfsr_ff[0]};
    return {lfsr_ff, ~lfsr_ff};
  endfunction : rnd

  function automatic logic [31:0] st_w(input logic [5:0] op3, input logic i,
                                       input logic [7:0] off);
    return {OP_FMT3, 5'h2, op3, 5'h1, i, off, 5'h3};
  endfunction : st_w

  // prefix fields are {paired, dest, src1, src2, src3} per instruction
  function automatic logic [31:0] px_w(input logic two, input logic [12:0] f,
                                       input logic [12:0] s);
    return {2'h0, two, f[12:9], OP2_PREFIX, f[8:0], s};
  endfunction : px_w

  function automatic logic [7:0] msk(input logic [63:0] a,
                                     input logic [63:0] st, input logic z);
    return z ? 8'h00 : (st == STEP_DBL) ? MASK_ALL : a[2] ? MASK_HI : MASK_LO;
  endfunction : msk

  task automatic check(input logic ok, input string what);
    samples_checked++;
    if (!ok) begin
      errors++;
      $display("Error %0t: %s", $time, what);
    end
  endtask : check

  task automatic wrap_up();
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // single bus transfer: address phase, then data phase, each held until hready is high
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    q = hrdata;
    // track translation enable for the lookup expectation
    if (wr && a == REG_CTRL) mmu = d[CTRL_MMU];
    check(hresp === 1'b0 && n < 100, "bus answer");
    if (n >= 100) wrap_up();
  endtask : bus

  // present one instruction and note what it must produce
  task automatic go(input logic [31:0] w, input logic [63:0] a,
                    input logic s, input exc_e ex, input int nst,
                    input logic z, input logic ds);
    int n;
    logic [63:0] ad, db, de, st;
    n = 0;
    db = rnd();
    de = rnd();
    ad = a + {{54{w[12]}}, w[12:5], 2'h0};
    st = (w[24:19] == OP3_DBL) ? STEP_DBL : STEP_SGL;
    @(posedge hclk);
    ins_valid <= 1'b1;
    ins_word <= w;
    src1_val <= a;
    cond_sign <= s;
    ins_delay_slot <= ds;
    st_data_basic <= db;
    st_data_ext <= de;
    do begin
      @(negedge hclk);
      n++;
    end while (ins_ready !== 1'b1 && n < 50);
    check(n < 50, "issue stuck");
    if (n >= 50) wrap_up();
    // lookup shown for conditional stores with the i bit set and translation enabled, both halves
    if (w[OP_LO+:2] == OP_FMT3) check(lookup_req === (w[IMM_BIT] & mmu) &&
        lookup_addr === ad && lookup_addr_ext === ad + st, "lookup");
    @(posedge hclk);
    ins_valid <= 1'b0;
    n_st += nst;
    if (ds) exp_q.push_back('{2'h2, EXC_NONE, 64'h0, 64'h0, 8'h0});
    if (ex != EXC_NONE) begin
      n_exc++;
      exp_q.push_back('{2'h1, ex, 64'h0, 64'h0, 8'h0});
    end
    for (int k = 0; k < nst; k++) begin
      exp_q.push_back('{2'h0, EXC_NONE, ad + st * k, k ? de : db,
                        msk(ad + st * k, st, z)});
    end
  endtask : go

  task automatic px(input logic two, input logic [12:0] f);
    go(px_w(two, f, 13'h0), b, 1'b0, EXC_NONE, 0, 1'b0, 1'b0);
  endtask : px

  // results are matched to notes in the order they appear
  always @(negedge hclk) begin
    if (hresetn === 1'b1 && (exc.valid === 1'b1 || insert_toc === 1'b1 ||
        (st_valid === 1'b1 && st_ready === 1'b1))) begin
      if (exp_q.size() == 0) begin
        check(1'b0, "unexpected result");
      end else begin
        cur = exp_q.pop_front();
        if (cur.kind == 2'h1) check(exc.valid === 1'b1 &&
                                    exc.code === cur.code, "fault code");
        else if (cur.kind == 2'h2) check(insert_toc === 1'b1, "inserted trap");
        else check(st_valid === 1'b1 && st_req.addr === cur.addr &&
                   st_req.mask === cur.mask && st_req.data === cur.data,
                   "store");
      end
    end
  end

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial begin
    {hresetn, hsel, hwrite, ins_valid, ins_delay_slot, cond_sign} = '0;
    {haddr, hwdata, htrans, ins_word, cfg, perm_cfg, stall} = '0;
    {src1_val, st_data_basic, st_data_ext} = '0;
    hsize = 3'h2;
    proc_state_fp_enable = 1'b1;
    fp_status_enable = 1'b1;
    {errors, samples_checked, n_exc, n_st} = '0;
    mmu = 1'b1;
    lfsr_ff = 32'h5209;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    b = rnd() & ~64'hF;
    bus(1'b0, REG_CTRL, 32'h0, rd);
    check(rd === 32'h2, "control reset");
    go(st_w(OP3_SGL, 1'b1, 8'hFE), b, 1'b1, EXC_NONE, 1, 1'b0, 1'b0);
    go(st_w(OP3_SGL, 1'b1, 8'h01), b, 1'b1, EXC_NONE, 1, 1'b0, 1'b0);
    go(st_w(OP3_SGL, 1'b1, 8'h01), b, 1'b0, EXC_NONE, 0, 1'b0, 1'b0);
    cfg <= 5'h02;
    go(st_w(OP3_SGL, 1'b1, 8'h01), b, 1'b0, EXC_NONE, 1, 1'b1, 1'b0);
    go(st_w(OP3_DBL, 1'b1, 8'h02), b, 1'b1, EXC_NONE, 1, 1'b1, 1'b0);
    cfg <= 5'h00;
    go(st_w(OP3_DBL, 1'b1, 8'h02), b, 1'b0, EXC_NONE, 1, 1'b0, 1'b0);
    go(st_w(OP3_SGL, 1'b1, 8'h00), b + 2, 1'b1, EXC_MISALIGN, 0, 1'b0, 1'b0);
    go(st_w(OP3_DBL, 1'b1, 8'h00), b + 2, 1'b0, EXC_MISALIGN, 0, 1'b0, 1'b0);
    go(st_w(OP3_DBL, 1'b1, 8'h01), b, 1'b0, EXC_DBL_MIS, 0, 1'b0, 1'b0);
    go(st_w(OP3_SGL, 1'b0, 8'h00), b, 1'b1, EXC_ILL_INSTR, 0, 1'b0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      proc_state_fp_enable <= k[0];
      fp_status_enable <= !k[0];
      go(st_w(OP3_SGL, 1'b1, 8'h00), b, 1'b1, EXC_FP_DIS, 0, 1'b0, 1'b0);
    end
    proc_state_fp_enable <= 1'b1;
    fp_status_enable <= 1'b1;
    cfg <= 5'h08;
    go(st_w(OP3_SGL, 1'b1, 8'h00), b, 1'b0, EXC_WATCH, 0, 1'b0, 1'b0);
    cfg <= 5'h01;
    go(st_w(OP3_SGL, 1'b1, 8'h00), b, 1'b0, EXC_TLB_MISS, 0, 1'b0, 1'b0);
    cfg <= 5'h00;
    for (int k = 1; k < 4; k++) begin
      perm_cfg <= k[1:0];
      go(st_w(OP3_SGL, 1'b1, 8'h00), b, 1'b0, exc_e'(4'h7 + k), 0, 1'b0, 1'b0);
    end
    perm_cfg <= 2'h0;
    stall <= 2'h2;
    px(1'b0, 13'h1000);
    go(st_w(OP3_SGL, 1'b1, 8'h02), b, 1'b1, EXC_NONE, 2, 1'b0, 1'b0);
    go(st_w(OP3_SGL, 1'b1, 8'h01), b, 1'b1, EXC_NONE, 1, 1'b0, 1'b0);
    px(1'b0, 13'h1000);
    go(st_w(OP3_SGL, 1'b1, 8'h01), b, 1'b1, EXC_MISALIGN, 0, 1'b0, 1'b0);
    px(1'b1, 13'h1000);
    go(st_w(OP3_DBL, 1'b1, 8'h02), b, 1'b0, EXC_MISALIGN, 0, 1'b0, 1'b0);
    go(st_w(OP3_DBL, 1'b1, 8'h01), b, 1'b0, EXC_DBL_MIS, 0, 1'b0, 1'b0);
    px(1'b0, 13'h1000);
    go(st_w(OP3_DBL, 1'b1, 8'h04), b, 1'b0, EXC_NONE, 2, 1'b0, 1'b0);
    cfg <= 5'h02;
    px(1'b0, 13'h1000);
    go(st_w(OP3_SGL, 1'b1, 8'h00), b, 1'b1, EXC_DACC, 0, 1'b0, 1'b0);
    cfg <= 5'h06;
    px(1'b0, 13'h1000);
    go(st_w(OP3_SGL, 1'b1, 8'h00), b, 1'b1, EXC_NONE, 2, 1'b0, 1'b0);
    cfg <= 5'h10;
    px(1'b0, 13'h1000);
    go(st_w(OP3_SGL, 1'b1, 8'h00), b, 1'b1, EXC_WATCH, 0, 1'b0, 1'b0);
    cfg <= 5'h00;
    // illegal extension fields and nested prefix
    for (int k = 0; k < 3; k++) begin
      px(1'b0, k == 0 ? 13'h0080 : k == 1 ? 13'h0004 : 13'h1800);
      go(st_w(OP3_SGL, 1'b1, 8'h00), b, 1'b1, EXC_ILL_ACT, 0, 1'b0, 1'b0);
    end
    px(1'b0, 13'h1000);
    go(px_w(1'b0, 13'h1000, 13'h0), b, 1'b0, EXC_ILL_ACT, 0, 1'b0, 1'b0);
    go(st_w(OP3_SGL, 1'b1, 8'h00), b, 1'b1, EXC_NONE, 2, 1'b0, 1'b0);
    // delay slot prefix, second fields ignored
    b = rnd() & ~64'hF;
    go(px_w(1'b0, 13'h0, 13'h1FFF), b, 1'b0, EXC_NONE, 0, 1'b0, 1'b1);
    go(st_w(OP3_SGL, 1'b1, 8'h00), b, 1'b1, EXC_NONE, 1, 1'b0, 1'b0);
    go(st_w(OP3_SGL, 1'b1, 8'h00), b, 1'b1, EXC_NONE, 1, 1'b0, 1'b0);
    bus(1'b1, REG_CTRL, 32'h3, rd);
    go(st_w(OP3_DBL, 1'b1, 8'h00), b, 1'b1, EXC_NONE, 1, 1'b0, 1'b0);
    go(st_w(OP3_DBL, 1'b1, 8'h00), b, 1'b0, EXC_NONE, 0, 1'b0, 1'b0);
    bus(1'b1, REG_CTRL, 32'h1, rd);
    go(st_w(OP3_SGL, 1'b1, 8'h00), b, 1'b1, EXC_NONE, 1, 1'b0, 1'b0);
    for (int k = 0; k < 50 && exp_q.size() != 0; k++) @(posedge hclk);
    check(exp_q.size() == 0, "results missing");
    bus(1'b0, REG_CTRL, 32'h0, rd);
    check(rd === 32'h1, "control readback");
    bus(1'b0, 8'h20, 32'h0, rd);
    check(rd === 32'h0, "unmapped read");
    bus(1'b0, REG_EXCS, 32'h0, rd);
    check(rd === n_exc[31:0], "fault count");
    bus(1'b0, REG_STORES, 32'h0, rd);
    check(rd === n_st[31:0], "store count");
    wrap_up();
  end
endmodule : cond_fp_store_prefix_tb
